//--- verilog/line_seq_pkg.sv
// Constants and types shared by the line activation sequencer.
// Assumes a 10 MHz system clock and a separate link clock.
// Notes on behaviour
// - Sequencer runs full start-up without host help
// - Optional breakpoints pause sequence for host
// - Same codes in both host modes
// - Serial mode: write command, read indication registers
// - Link mode: codes carried in command/indicate slot
// - Full reset sends and hears only null signals
// - Full reset has powered-down and powered-up substates
// - Powered down: only tone detect, outputs low-impedance
// - Powered down keeps all register contents
// - Supply-on: power down, defaults, cold start 15 s
// - Power-down command keeps registers and coefficients
// - Warm start after prior activation, supply held
// - Verified two-byte message ends with end marker
// - Message byte one address, byte two value
// - Message priority fixed; new readback replaces old
// - Supervision timer on by default, expiry exits activation
package line_seq_pkg;
   typedef enum logic [3:0] {
      ST_POWER_OFF, ST_FULL_RESET, ST_ALERTING, ST_AWAKE, ST_TRAINING,
      ST_SYNC, ST_ACTIVE, ST_DEACT, ST_TEAR_DOWN
   } seq_state_t;
   localparam logic [3:0] CMD_ACTIVATE   = 4'h8;
   localparam logic [3:0] CMD_DEACTIVATE = 4'h9;
   localparam logic [3:0] CMD_POWER_DOWN = 4'hF;
   localparam logic [3:0] CMD_CONTINUE   = 4'hA;
   localparam logic [3:0] CMD_NONE       = 4'h0;
   localparam logic [3:0] IND_POWER_OFF  = 4'h0;
   localparam logic [3:0] IND_RESET      = 4'h1;
   localparam logic [3:0] IND_PENDING    = 4'h4;
   localparam logic [3:0] IND_ACTIVE     = 4'hC;
   localparam logic [3:0] IND_BREAK      = 4'h6;
   localparam logic [3:0] IND_TIMEOUT    = 4'hE;
   localparam int CLK_HZ           = 10000000;
   localparam int SUPERVISION_SEC  = 15;
   localparam longint SUPERVISION_CYC = longint'(SUPERVISION_SEC) * CLK_HZ;
   localparam int WARM_MS          = 300;
   localparam int WARM_CYC         = WARM_MS * (CLK_HZ / 1000);
   localparam int TONE_MS          = 3;
   localparam int TONE_CYC         = TONE_MS * (CLK_HZ / 1000);
   localparam int TRAIN_DEF        = 16;
   localparam logic [1:0] MSG_MAINT = 2'h0;
   localparam logic [1:0] MSG_EOC   = 2'h1;
   localparam logic [1:0] MSG_SPARE = 2'h2;
   localparam logic [1:0] MSG_BEC   = 2'h3;
   localparam int MSG_SRC          = 5;
   localparam int RB_IDX           = 4;
   localparam logic [7:0] RST_BYTE  = 8'h00;
endpackage

//--- verilog/msg_link_if.sv
// Carrier between core and link side: message byte handshake.
// Assumes producer in system domain, consumer crosses it.
`timescale 1ns/1ps
interface msg_link_if;
   logic       req_tgl;
   logic       ack_tgl;
   logic [7:0] data;
   logic       last;
   modport src (output req_tgl, output data, output last, input ack_tgl);
   modport dst (input req_tgl, input data, input last, output ack_tgl);
endinterface

//--- verilog/msg_arbiter.sv
// Fixed-priority monitor message source with one readback slot.
// Assumes sources pulse a request with address and value.
`timescale 1ns/1ps
module msg_arbiter #(
   parameter int NSRC = 5
) (
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  ce_i,
   input  wire logic [NSRC-1:0]       post_i,
   input  wire logic [NSRC-1:0][15:0] word_i,
   msg_link_if.src                    link
);
   typedef struct packed {
      logic [NSRC-1:0]       pend;
      logic [NSRC-1:0][15:0] word;
      logic [15:0]           cur;
      logic                  busy;
      logic                  second;
      logic                  req_tgl;
      logic [7:0]            data;
      logic                  last;
      logic                  ack_s1;
      logic                  ack_s2;
      logic                  ack_q;
   } arb_t;
   arb_t s_r, s_nxt;
   logic ack_evt;
   initial begin
      if (NSRC != line_seq_pkg::MSG_SRC) $error("NSRC must be 5");
   end
   assign ack_evt = s_r.ack_s2 ^ s_r.ack_q;
   always_comb begin
      int   pick;
      logic found;
      pick  = 0;
      found = 1'b0;
      s_nxt = s_r;
      s_nxt.ack_s1 = link.ack_tgl;
      s_nxt.ack_s2 = s_r.ack_s1;
      s_nxt.ack_q  = s_r.ack_s2;
      for (int i = NSRC - 1; i >= 0; i--) begin
         // Lowest index wins: maintenance first, readback last
         if (s_r.pend[i]) begin
            found = 1'b1;
            pick  = i;
         end
      end
      if (s_r.busy && ack_evt) begin
         if (!s_r.second) begin
            s_nxt.second  = 1'b1;
            s_nxt.data    = s_r.cur[7:0];
            s_nxt.last    = 1'b1;
            s_nxt.req_tgl = ~s_r.req_tgl;
         end else begin
            s_nxt.busy = 1'b0;
         end
      end else if (!s_r.busy && found) begin
         // Own hold word, so a fresh post cannot alter the value half
         s_nxt.busy       = 1'b1;
         s_nxt.second     = 1'b0;
         s_nxt.cur        = s_r.word[pick];
         s_nxt.data       = s_r.word[pick][15:8];
         s_nxt.last       = 1'b0;
         s_nxt.pend[pick] = 1'b0;
         s_nxt.req_tgl    = ~s_r.req_tgl;
      end
      // Posts after the pick, so a same-cycle post stays pending
      for (int i = 0; i < NSRC; i++) begin
         // Newer post overwrites; readback slot thus keeps one
         if (post_i[i]) begin
            s_nxt.pend[i] = 1'b1;
            s_nxt.word[i] = word_i[i];
         end
      end
      if (!resetn_i) s_nxt = '0;
      else if (!ce_i) s_nxt = s_r;
   end
   always_ff @(posedge clk_i) begin
      s_r <= s_nxt;
   end
   assign link.req_tgl = s_r.req_tgl;
   assign link.data    = s_r.data;
   assign link.last    = s_r.last;
endmodule

//--- verilog/line_activation_sequencer.sv
// Activation sequencer top: host command port, line status, monitor out.
// Assumes line events are level pins; link clock drives message serial out.
`timescale 1ns/1ps
module line_activation_sequencer #(
   parameter longint SUPERVISION_CYCLES = line_seq_pkg::SUPERVISION_CYC,
   parameter int     WARM_CYCLES        = line_seq_pkg::WARM_CYC,
   parameter int     TONE_CYCLES        = line_seq_pkg::TONE_CYC,
   parameter int     TRAIN_CYCLES       = line_seq_pkg::TRAIN_DEF
) (
   // System
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       ce_i,
   // Supply and mode
   input  wire logic       supply_ok_i,
   input  wire logic       serial_mode_i,
   input  wire logic       breakpoint_en_i,
   input  wire logic       supervision_en_i,
   // Host command: serial register write or link command slot
   input  wire logic       cmd_wr_i,
   input  wire logic [7:0] command_out_reg_i,
   input  wire logic       link_cmd_frame_i,
   input  wire logic [7:0] link_cmd_i,
   // Line status pins
   input  wire logic       line_tone_detect_i,
   input  wire logic       line_sync_i,
   input  wire logic       line_loss_i,
   // Monitor message posts
   input  wire logic [4:0]       msg_post_i,
   input  wire logic [4:0][15:0] msg_word_i,
   // Link side
   input  wire logic       link_clk_i,
   input  wire logic       link_resetn_i,
   output logic            mon_valid_o,
   output logic [7:0]      mon_byte_o,
   output logic            message_end_marker_o,
   // Status
   output logic [7:0]      line_state_indication_reg_o,
   output logic [7:0]      indicate_link_o,
   output logic            tx_null_o,
   output logic            wake_tone_o,
   output logic            powered_up_o,
   output logic            warm_start_o,
   output logic            outputs_low_z_o,
   output logic            line_drv_oe_n_o
);
   typedef struct packed {
      line_seq_pkg::seq_state_t state;
      logic        powered_up;
      logic        was_active;
      logic        warm;
      logic [3:0]  cmd;
      logic        cmd_new;
      logic        held;
      logic [35:0] sup_cnt;
      logic        sup_run;
      logic [31:0] step_cnt;
      logic [2:0]  tone_s;
      logic [2:0]  sync_s;
      logic [2:0]  loss_s;
      logic [1:0]  sup_s;
      logic [7:0]  ind;
      logic        tx_null;
      logic        wake;
      logic        low_z;
   } core_t;
   core_t c_r, c_nxt;
   msg_link_if ml();
   logic tone_q, sync_q, loss_q;
   logic [3:0] cmd_in;
   logic       cmd_strobe;
   logic       sup_expired;
   initial begin
      if (TRAIN_CYCLES < 1 || WARM_CYCLES < 1 || TONE_CYCLES < 1)
         $error("Cycle counts must be at least one");
      if (SUPERVISION_CYCLES < 1 || SUPERVISION_CYCLES > 64'h0000000FFFFFFFFF)
         $error("Supervision count out of range");
   end
   assign tone_q = c_r.tone_s[1];
   assign sync_q = c_r.sync_s[1];
   assign loss_q = c_r.loss_s[1];
   // Both host modes feed one decoder with the same codes
   assign cmd_in     = serial_mode_i ? command_out_reg_i[3:0]
                                     : link_cmd_i[3:0];
   // Host repeats the slot every frame; only a change is acted upon
   assign cmd_strobe = serial_mode_i ? cmd_wr_i
                      : (link_cmd_frame_i && link_cmd_i[3:0] != c_r.cmd);
   assign sup_expired = c_r.sup_run && c_r.sup_s[1]
                        && (c_r.sup_cnt >= 36'(SUPERVISION_CYCLES));
   always_comb begin
      c_nxt = c_r;
      c_nxt.tone_s = {c_r.tone_s[1:0], line_tone_detect_i};
      c_nxt.sync_s = {c_r.sync_s[1:0], line_sync_i};
      c_nxt.loss_s = {c_r.loss_s[1:0], line_loss_i};
      c_nxt.sup_s  = {c_r.sup_s[0], supervision_en_i};
      c_nxt.cmd_new = 1'b0;
      if (cmd_strobe) begin
         c_nxt.cmd     = cmd_in;
         c_nxt.cmd_new = 1'b1;
      end
      if (c_r.sup_run) c_nxt.sup_cnt = c_r.sup_cnt + 36'h1;
      if (c_r.step_cnt != 32'h0) c_nxt.step_cnt = c_r.step_cnt - 32'h1;
      unique case (c_r.state)
         line_seq_pkg::ST_POWER_OFF: begin
            // Supply-on enters reset powered down, cold
            if (supply_ok_i) begin
               c_nxt.state      = line_seq_pkg::ST_FULL_RESET;
               c_nxt.powered_up = 1'b0;
               c_nxt.was_active = 1'b0;
            end
         end
         line_seq_pkg::ST_FULL_RESET: begin
            // Power-down keeps coefficients and history
            if (c_r.cmd_new && c_r.cmd == line_seq_pkg::CMD_POWER_DOWN)
               c_nxt.powered_up = 1'b0;
            else if (c_r.cmd_new && c_r.cmd == line_seq_pkg::CMD_ACTIVATE) begin
               // Request starts supervision and alerting
               c_nxt.state      = line_seq_pkg::ST_ALERTING;
               c_nxt.powered_up = 1'b1;
               c_nxt.warm       = c_r.was_active;
               c_nxt.sup_run    = 1'b1;
               c_nxt.sup_cnt    = 36'h0;
               c_nxt.step_cnt   = 32'(TONE_CYCLES);
            end else if (tone_q)
               c_nxt.powered_up = 1'b1;  // Tone detect stays alive
         end
         line_seq_pkg::ST_ALERTING:
            if (c_r.step_cnt == 32'h0) begin
               c_nxt.state    = line_seq_pkg::ST_AWAKE;
            end
         line_seq_pkg::ST_AWAKE:
            if (tone_q) begin
               c_nxt.state    = line_seq_pkg::ST_TRAINING;
               // Warm start skips full coefficient computation
               c_nxt.step_cnt = c_r.warm ? 32'(WARM_CYCLES)
                                          : 32'(TRAIN_CYCLES);
            end
         line_seq_pkg::ST_TRAINING:
            if (c_r.step_cnt == 32'h0 && sync_q) begin
               // Optional breakpoint waits for host continue
               if (breakpoint_en_i && !c_r.held) c_nxt.held = 1'b1;
               else if (!breakpoint_en_i || (c_r.cmd_new
                        && c_r.cmd == line_seq_pkg::CMD_CONTINUE)) begin
                  c_nxt.held  = 1'b0;
                  c_nxt.state = line_seq_pkg::ST_SYNC;
               end
            end
         line_seq_pkg::ST_SYNC: begin
            c_nxt.state      = line_seq_pkg::ST_ACTIVE;
            c_nxt.sup_run    = 1'b0;
            c_nxt.was_active = 1'b1;
         end
         line_seq_pkg::ST_ACTIVE:
            if ((c_r.cmd_new && c_r.cmd == line_seq_pkg::CMD_DEACTIVATE)
                || loss_q) begin
               c_nxt.state = line_seq_pkg::ST_DEACT;
            end
         line_seq_pkg::ST_DEACT:
            c_nxt.state = line_seq_pkg::ST_TEAR_DOWN;
         line_seq_pkg::ST_TEAR_DOWN: begin
            c_nxt.state   = line_seq_pkg::ST_FULL_RESET;
            c_nxt.sup_run = 1'b0;
         end
      endcase
      // Expiry forces the sequencer out of activation
      if (sup_expired && c_r.state inside {line_seq_pkg::ST_ALERTING,
          line_seq_pkg::ST_AWAKE, line_seq_pkg::ST_TRAINING}) begin
         c_nxt.state   = line_seq_pkg::ST_TEAR_DOWN;
         c_nxt.sup_run = 1'b0;
         c_nxt.held    = 1'b0;
      end
      // Loss of supply returns to power-off from anywhere
      if (!supply_ok_i) begin
         c_nxt.state      = line_seq_pkg::ST_POWER_OFF;
         c_nxt.powered_up = 1'b0;
         c_nxt.was_active = 1'b0;
         c_nxt.sup_run    = 1'b0;
      end
      // Null transmit in power-off, full reset, awake, deactivation and teardown states
      c_nxt.tx_null = c_nxt.state inside {line_seq_pkg::ST_POWER_OFF,
         line_seq_pkg::ST_FULL_RESET, line_seq_pkg::ST_AWAKE,
         line_seq_pkg::ST_DEACT, line_seq_pkg::ST_TEAR_DOWN};
      c_nxt.wake  = c_nxt.state == line_seq_pkg::ST_ALERTING;
      // Low-impedance outputs while powered down
      c_nxt.low_z = !c_nxt.powered_up;
      unique case (c_nxt.state)
         line_seq_pkg::ST_POWER_OFF:  c_nxt.ind = {4'h0,
                                           line_seq_pkg::IND_POWER_OFF};
         line_seq_pkg::ST_FULL_RESET: c_nxt.ind = {3'h0, c_nxt.powered_up,
                                           line_seq_pkg::IND_RESET};
         line_seq_pkg::ST_ACTIVE:     c_nxt.ind = {4'h0,
                                           line_seq_pkg::IND_ACTIVE};
         line_seq_pkg::ST_TEAR_DOWN:  c_nxt.ind = {4'h0,
                                           line_seq_pkg::IND_TIMEOUT};
         default:                     c_nxt.ind = {3'h0, c_nxt.held,
                                           line_seq_pkg::IND_PENDING};
      endcase
      if (c_nxt.held) c_nxt.ind = {4'h0, line_seq_pkg::IND_BREAK};
      // Out of reset powered down, so outputs start parked
      if (!resetn_i) begin
         c_nxt       = '0;
         c_nxt.low_z = 1'b1;
      end else if (!ce_i)
         c_nxt = c_r;
   end
   always_ff @(posedge clk_i) begin
      c_r <= c_nxt;
   end
   // Monitor message arbitration in the system domain
   msg_arbiter #(
      .NSRC(line_seq_pkg::MSG_SRC)
   ) u_arb (
      .clk_i   (clk_i),
      .resetn_i(resetn_i),
      .ce_i    (ce_i),
      .post_i  (msg_post_i),
      .word_i  (msg_word_i),
      .link    (ml.src)
   );
   // Link domain: toggle crossing, byte sent one link cycle each
   typedef struct packed {
      logic [2:0] req_s;
      logic       ack_tgl;
      logic       valid;
      logic [7:0] byte_v;
      logic       message_end_marker;
   } lnk_t;
   lnk_t l_r, l_nxt;
   always_comb begin
      l_nxt = l_r;
      l_nxt.req_s = {l_r.req_s[1:0], ml.req_tgl};
      l_nxt.valid = 1'b0;
      l_nxt.message_end_marker   = 1'b0;
      if (l_r.req_s[2] != l_r.req_s[1]) begin
         // Address then value; marker only with the second
         l_nxt.valid   = 1'b1;
         l_nxt.byte_v  = ml.data;
         l_nxt.message_end_marker     = ml.last;
         l_nxt.ack_tgl = l_r.req_s[1];
      end
      if (!link_resetn_i) l_nxt = '0;
   end
   always_ff @(posedge link_clk_i) begin
      l_r <= l_nxt;
   end
   assign ml.ack_tgl = l_r.ack_tgl;
   assign mon_valid_o          = l_r.valid;
   assign mon_byte_o           = l_r.byte_v;
   assign message_end_marker_o = l_r.message_end_marker;
   assign line_state_indication_reg_o = c_r.ind;
   assign indicate_link_o      = c_r.ind;
   assign tx_null_o            = c_r.tx_null;
   assign wake_tone_o          = c_r.wake;
   assign powered_up_o         = c_r.powered_up;
   assign warm_start_o         = c_r.warm;
   assign outputs_low_z_o      = c_r.low_z;
   assign line_drv_oe_n_o      = c_r.low_z;
   a_alert_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && c_r.state == line_seq_pkg::ST_FULL_RESET && c_r.cmd_new
      && c_r.cmd == line_seq_pkg::CMD_ACTIVATE && supply_ok_i
      |=> c_r.state == line_seq_pkg::ST_ALERTING && c_r.sup_run)
      else $error("Activate did not start alerting");
   a_power_loss: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && !supply_ok_i |=> c_r.state == line_seq_pkg::ST_POWER_OFF)
      else $error("Supply loss did not reach power-off");
   a_null_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
      c_r.state == line_seq_pkg::ST_FULL_RESET |-> c_r.tx_null && !c_r.wake)
      else $error("Line signal in full reset");
   a_low_z_down: assert property (@(posedge clk_i) disable iff (!resetn_i)
      c_r.low_z == !c_r.powered_up)
      else $error("Output impedance disagrees with power");
   a_pdn_keeps: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && supply_ok_i && c_r.state == line_seq_pkg::ST_FULL_RESET
      |=> c_r.was_active == $past(c_r.was_active))
      else $error("Reset substate lost history");
   a_sup_expiry: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && supply_ok_i && sup_expired
      && c_r.state == line_seq_pkg::ST_TRAINING
      |=> c_r.state == line_seq_pkg::ST_TEAR_DOWN)
      else $error("Expiry ignored");
   a_warm_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(c_r.state == line_seq_pkg::ST_ALERTING)
      |-> c_r.warm == $past(c_r.was_active))
      else $error("Warm start choice wrong");
   a_break_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      c_r.held |-> c_r.ind[3:0] == line_seq_pkg::IND_BREAK)
      else $error("Breakpoint not indicated");
   a_eom_last: assert property (@(posedge link_clk_i)
      disable iff (!link_resetn_i)
      l_r.message_end_marker |-> l_r.valid)
      else $error("Marker without byte");
endmodule

//--- testbench/host_model.sv
// Host-side controller model: command slot and monitor receiver.
// Assumes frames follow the system clock, bytes the link clock.
`timescale 1ns/1ps
module host_model (
   // Clocks and reset
   input  wire logic        clk_i,
   input  wire logic        link_clk_i,
   input  wire logic        resetn_i,
   // Command and indication slot
   input  wire logic [7:0]  cmd_i,
   output logic             frame_o,
   output logic [7:0]       slot_o,
   input  wire logic [7:0]  ind_i,
   output logic [7:0]       ind_r_o,
   // Monitor channel
   input  wire logic        valid_i,
   input  wire logic [7:0]  byte_i,
   input  wire logic        end_i,
   output logic [3:0][15:0] msg_o,
   output logic [2:0]       msg_cnt_o
);
   logic [2:0] fcnt;
   logic [7:0] ind_prev;
   logic [7:0] addr_r;
   logic       second;
   initial begin
      fcnt = 3'h0;
      frame_o = 1'b0;
      slot_o = 8'h00;
   end
   // Slot is garbage outside frames so stale values cannot pass
   always @(negedge clk_i) begin
      fcnt <= resetn_i ? fcnt + 3'h1 : 3'h0;
      frame_o <= resetn_i && fcnt == 3'h0;
      slot_o <= (resetn_i && fcnt == 3'h0) ? cmd_i : ~cmd_i;
   end
   // Latch only after two equal frames
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         ind_prev <= 8'h00;
         ind_r_o <= 8'h00;
      end else if (frame_o) begin
         ind_prev <= ind_i;
         if (ind_i === ind_prev) ind_r_o <= ind_i;
      end
   end
   // Odd byte is address, even byte value; kept only with marker
   always @(posedge link_clk_i) begin
      // Reset works as an abort: partial message dropped, count cleared
      if (!resetn_i) begin
         second <= 1'b0;
         addr_r <= 8'h00;
         msg_cnt_o <= 3'h0;
         msg_o <= '0;
      end else if (valid_i) begin
         second <= !second;
         if (!second) addr_r <= byte_i;
         else if (end_i && msg_cnt_o < 3'h4) begin
            msg_o[msg_cnt_o[1:0]] <= {addr_r, byte_i};
            msg_cnt_o <= msg_cnt_o + 3'h1;
         end
      end
   end
endmodule

//--- testbench/line_activation_sequencer_tb_top.sv
// Testbench for the line activation sequencer.
// Assumes short parameter values for timers; host model on the slot.
`timescale 1ns/1ps
module line_activation_sequencer_tb_top;
   logic clk_i = 0, link_clk_i = 0, resetn_i = 0, supply = 0;
   logic ser = 1, brk = 0, sup_en = 1, cmd_wr = 0, tone = 0, sync = 0;
   logic [7:0] cmd_reg = 8'h00, host_cmd = 8'h00;
   logic [4:0] post = 5'h00;
   logic [4:0][15:0] word = '0;
   logic mon_v, message_end_marker, tx_null, wake, pwr_up, warm, low_z;
   logic frame;
   logic ce = 1, oe_n;
   logic [7:0] mon_b, ind, ind_lnk, slot, ind_r;
   logic [3:0][15:0] msg;
   logic [2:0] msg_cnt;
   int fail_count = 0, checks = 0;

   initial forever #50 clk_i = ~clk_i;
   initial begin
      #3;
      forever #6 link_clk_i = ~link_clk_i;
   end

   line_activation_sequencer #(.SUPERVISION_CYCLES(2000),
      .WARM_CYCLES(20), .TONE_CYCLES(5), .TRAIN_CYCLES(16)) dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
      .supply_ok_i(supply), .serial_mode_i(ser),
      .breakpoint_en_i(brk), .supervision_en_i(sup_en),
      .cmd_wr_i(cmd_wr), .command_out_reg_i(cmd_reg),
      .link_cmd_frame_i(frame), .link_cmd_i(slot),
      .line_tone_detect_i(tone), .line_sync_i(sync),
      .line_loss_i(1'b0), .msg_post_i(post), .msg_word_i(word),
      .link_clk_i(link_clk_i), .link_resetn_i(resetn_i),
      .mon_valid_o(mon_v), .mon_byte_o(mon_b),
      .message_end_marker_o(message_end_marker),
      .line_state_indication_reg_o(ind), .indicate_link_o(ind_lnk),
      .tx_null_o(tx_null), .wake_tone_o(wake),
      .powered_up_o(pwr_up), .warm_start_o(warm),
      .outputs_low_z_o(low_z), .line_drv_oe_n_o(oe_n));

   host_model host (
      .clk_i(clk_i), .link_clk_i(link_clk_i), .resetn_i(resetn_i),
      .cmd_i(host_cmd), .frame_o(frame), .slot_o(slot),
      .ind_i(ind_lnk), .ind_r_o(ind_r), .valid_i(mon_v),
      .byte_i(mon_b), .end_i(message_end_marker), .msg_o(msg), .msg_cnt_o(msg_cnt));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [3:0] c);
      @(negedge clk_i);
      cmd_wr = 1;
      cmd_reg = {4'h0, c};
      @(negedge clk_i);
      cmd_wr = 0;
   endtask

   // Bounded wait on the device or host-latched indication
   task automatic wait_ind(input logic [7:0] e, input int lim,
                           input bit lnk);
      int n;
      n = 0;
      while ((lnk ? ind_r : ind) !== e && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      check({8'h00, lnk ? ind_r : ind}, {8'h00, e});
   endtask

   task automatic test_done;
      $display("Checks %0d, errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #1200000;
      fail_count++;
      $display("Error at %0t: run did not finish", $time);
      test_done;
   end

   initial begin
      repeat (4) @(negedge clk_i);
      resetn_i = 1;
      repeat (2) @(negedge clk_i);
      check(ind, 8'h00);
      supply = 1;
      wait_ind(8'h01, 10, 0);
      check(tx_null, 1'b1);
      check({pwr_up, low_z, oe_n}, 3'b011);
      check(warm, 1'b0);
      cmd(line_seq_pkg::CMD_ACTIVATE);
      wait_ind(8'h04, 10, 0);
      check(wake, 1'b1);
      check({pwr_up, low_z, oe_n}, 3'b100);
      tone = 1;
      sync = 1;
      wait_ind(8'h0C, 300, 0);
      check(tx_null, 1'b0);
      // Readback replaced while the higher sources go first
      @(negedge clk_i);
      word[0] = 16'h1234;
      word[1] = 16'h2200;
      word[4] = 16'hA501;
      post = 5'b10011;
      @(negedge clk_i);
      word[4] = 16'hA502;
      post = 5'b10000;
      @(negedge clk_i);
      post = 5'h00;
      for (int n = 0; n < 200 && msg_cnt < 3; n++) @(negedge clk_i);
      repeat (20) @(negedge clk_i);
      check(msg_cnt, 3'h3);
      check(msg[0], 16'h1234);
      check(msg[1], 16'h2200);
      check(msg[2], 16'hA502);
      tone = 0;
      sync = 0;
      cmd(line_seq_pkg::CMD_DEACTIVATE);
      wait_ind(8'h11, 300, 0);
      check(pwr_up, 1'b1);
      cmd(line_seq_pkg::CMD_POWER_DOWN);
      wait_ind(8'h01, 10, 0);
      check({pwr_up, warm}, 2'b00);
      // Same codes through the slot, with a breakpoint
      ser = 0;
      brk = 1;
      host_cmd = {4'h0, line_seq_pkg::CMD_ACTIVATE};
      tone = 1;
      sync = 1;
      wait_ind(8'h06, 400, 1);
      check(warm, 1'b1);
      host_cmd = {4'h0, line_seq_pkg::CMD_CONTINUE};
      wait_ind(8'h0C, 400, 1);
      tone = 0;
      sync = 0;
      host_cmd = {4'h0, line_seq_pkg::CMD_DEACTIVATE};
      wait_ind(8'h11, 400, 1);
      // Supervision expiry, then the same with the timer off
      ser = 1;
      brk = 0;
      cmd(line_seq_pkg::CMD_ACTIVATE);
      wait_ind(8'h04, 10, 0);
      wait_ind(8'h0E, 2100, 0);
      for (int n = 0; n < 100 && ind[3:0] != 4'h1; n++) @(negedge clk_i);
      sup_en = 0;
      cmd(line_seq_pkg::CMD_ACTIVATE);
      wait_ind(8'h04, 10, 0);
      repeat (2200) @(negedge clk_i);
      check(ind, 8'h04);
      // Enable low freezes the sequencer even across supply loss
      ce = 0;
      supply = 0;
      repeat (5) @(negedge clk_i);
      check(ind, 8'h04);
      ce = 1;
      wait_ind(8'h00, 10, 0);
      test_done;
   end
endmodule
